// >>> lfc_ctrl.sv
// Frame control register with indirect access and controller hooks
`timescale 1ns/1ps
`default_nettype none
`include "lfc_defs.svh"

module lfc_ctrl
(
    input wire logic sys_clk,
    input wire logic rst,
    // Indirect register access
    input wire logic ptr_wr,
    input wire logic data_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Mode select, one is master
    input wire logic master_mode,
    // Events from the frame engine
    input wire logic break_seen,
    input wire logic sleep_frame_rx,
    input wire logic idle_timeout,
    input wire logic wakeup_rx,
    input wire logic wakeup_tx_done,
    input wire logic ack_taken,
    input wire logic frame_done,
    input wire logic frame_error,
    input wire logic irq_event,
    input wire logic [`LFC_ERR_BITS-1:0] err_event,
    // Commands to the frame engine
    output logic frame_start,
    output logic wakeup_tx,
    output logic data_ack,
    output logic transmit_dir,
    output logic halted,
    output logic asleep,
    output logic interrupt_pending,
    output logic error_pending
);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0] indirect_address_pointer;
    logic sleep_enable;
    logic direction_select;
    logic data_request_acknowledge;
    logic wakeup_send_request;
    logic frame_start_request;
    logic ctl_wr;
    lfc_pkg::lfc_power_t power;
    lfc_pkg::lfc_power_t next_power;
    lfc_flag_if fl ();

    // Write of one into a control bit
    function automatic logic wr_one(input logic wr, input logic [7:0] d, input int pos);
        wr_one = wr && d[pos];
    endfunction : wr_one

    assign ctl_wr = data_wr && (indirect_address_pointer == `LFC_ADDR_CTRL);

    // ----------------------------------------
    // Indirect address pointer
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            indirect_address_pointer <= 8'h00;
        else if (ptr_wr)
            indirect_address_pointer <= sfr_wdata;
    end

    // ----------------------------------------
    // Plain read/write bits
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sleep_enable <= 1'(`LFC_CTRL_RESET >> `LFC_CTRL_SLEEP);
            direction_select <= 1'b0;
        end
        else if (ctl_wr)
        begin
            direction_select <= sfr_wdata[`LFC_CTRL_DIR];
            if (!master_mode)
                sleep_enable <= sfr_wdata[`LFC_CTRL_SLEEP];
        end
    end

    // Acknowledge bit, a fresh write wins over the hand-off
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            data_request_acknowledge <= 1'b0;
        else if (!master_mode && wr_one(ctl_wr, sfr_wdata, `LFC_CTRL_ACK))
            data_request_acknowledge <= 1'b1;
        else if (ack_taken)
            data_request_acknowledge <= 1'b0;
    end

    // Start request, master only, held until the frame ends
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            frame_start_request <= 1'b0;
        else if (master_mode && wr_one(ctl_wr, sfr_wdata, `LFC_CTRL_START))
            frame_start_request <= 1'b1;
        else if (frame_done || frame_error)
            frame_start_request <= 1'b0;
    end

    // Start pulse to the frame engine on the write itself
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            frame_start <= 1'b0;
        else
            frame_start <= master_mode && wr_one(ctl_wr, sfr_wdata, `LFC_CTRL_START);
    end

    // Halt, slave only, lifted by the next break
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            halted <= 1'b0;
        else if (!master_mode && wr_one(ctl_wr, sfr_wdata, `LFC_CTRL_HALT))
            halted <= 1'b1;
        else if (break_seen)
            halted <= 1'b0;
    end

    // Wakeup request, cleared once the wakeup has gone out
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            wakeup_send_request <= 1'b0;
        else if (wr_one(ctl_wr, sfr_wdata, `LFC_CTRL_WAKE))
            wakeup_send_request <= 1'b1;
        else if (wakeup_tx_done)
            wakeup_send_request <= 1'b0;
    end

    // Wakeup transmit pulse on the request write
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            wakeup_tx <= 1'b0;
        else
            wakeup_tx <= wr_one(ctl_wr, sfr_wdata, `LFC_CTRL_WAKE);
    end

    // ----------------------------------------
    // Power state
    // ----------------------------------------
    always_comb
    begin
        next_power = power;
        unique case (power)
            lfc_pkg::LFC_AWAKE:
            begin
                if (wr_one(ctl_wr, sfr_wdata, `LFC_CTRL_WAKE))
                    next_power = lfc_pkg::LFC_WAKING;
                else if (!master_mode && sleep_enable && (sleep_frame_rx || idle_timeout))
                    next_power = lfc_pkg::LFC_ASLEEP;
            end
            lfc_pkg::LFC_ASLEEP:
            begin
                if (wr_one(ctl_wr, sfr_wdata, `LFC_CTRL_WAKE))
                    next_power = lfc_pkg::LFC_WAKING;
                else if (!master_mode && !sleep_enable && wakeup_rx)
                    next_power = lfc_pkg::LFC_AWAKE;
            end
            lfc_pkg::LFC_WAKING:
            begin
                // A fresh request in the done cycle keeps the wakeup going
                if (wakeup_tx_done && !wr_one(ctl_wr, sfr_wdata, `LFC_CTRL_WAKE))
                    next_power = lfc_pkg::LFC_AWAKE;
            end
            default:
            begin
                next_power = lfc_pkg::LFC_AWAKE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            power <= lfc_pkg::LFC_AWAKE;
        else
            power <= next_power;
    end

    // ----------------------------------------
    // Flag keeper and clear strobes
    // ----------------------------------------
    assign fl.irq_event = irq_event;
    assign fl.err_event = err_event;
    assign fl.clr_int = wr_one(ctl_wr, sfr_wdata, `LFC_CTRL_INTCLR);
    assign fl.clr_err = wr_one(ctl_wr, sfr_wdata, `LFC_CTRL_ERRCLR);

    lfc_flags u_flags
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .fl(fl.flags)
    );

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            data_ack <= 1'b0;
            transmit_dir <= 1'b0;
            asleep <= 1'b0;
            interrupt_pending <= 1'b0;
            error_pending <= 1'b0;
        end
        else
        begin
            data_ack <= data_request_acknowledge;
            transmit_dir <= direction_select;
            asleep <= (next_power == lfc_pkg::LFC_ASLEEP);
            interrupt_pending <= fl.int_pending;
            error_pending <= fl.err_any;
        end
    end

    // Indirect read data, write-only bits read as zero
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            sfr_rdata <= 8'h00;
        else if (indirect_address_pointer == `LFC_ADDR_CTRL)
            sfr_rdata <= {1'b0, sleep_enable, direction_select, data_request_acknowledge,
                          2'b00, wakeup_send_request, frame_start_request};
        else if (indirect_address_pointer == `LFC_ADDR_STATUS)
            sfr_rdata <= {4'h0, fl.int_pending, fl.err_any, 2'b00};
        else if (indirect_address_pointer == `LFC_ADDR_ERROR)
            sfr_rdata <= {3'b000, fl.err_bits};
        else
            sfr_rdata <= 8'h00;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_halt_write;
        !master_mode && ctl_wr && sfr_wdata[`LFC_CTRL_HALT];
    endsequence

    property p_halt_until_break;
        @(posedge sys_clk) disable iff (rst)
        s_halt_write ##1 !break_seen |=> halted;
    endproperty
    a_halt_until_break: assert property (p_halt_until_break) else $error("halt not held");

    property p_sleep_entry;
        @(posedge sys_clk) disable iff (rst)
        (power == lfc_pkg::LFC_AWAKE && !master_mode && sleep_enable && idle_timeout && !ctl_wr)
            |=> asleep;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

    property p_sleep_exit;
        @(posedge sys_clk) disable iff (rst)
        (power == lfc_pkg::LFC_ASLEEP && !master_mode && !sleep_enable && wakeup_rx && !ctl_wr)
            |=> power == lfc_pkg::LFC_AWAKE;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep not left");

    property p_ack_self_clear;
        @(posedge sys_clk) disable iff (rst)
        (ack_taken && !ctl_wr) |=> !data_request_acknowledge ##1 !data_ack;
    endproperty
    a_ack_self_clear: assert property (p_ack_self_clear) else $error("ack not cleared");

    property p_int_clear;
        @(posedge sys_clk) disable iff (rst)
        (fl.clr_int && !irq_event) |=> ##1 !interrupt_pending;
    endproperty
    a_int_clear: assert property (p_int_clear) else $error("interrupt not cleared");

    sequence s_wake_write;
        ctl_wr && sfr_wdata[`LFC_CTRL_WAKE];
    endsequence

    property p_wake_pulse;
        @(posedge sys_clk) disable iff (rst)
        s_wake_write |=> wakeup_tx && wakeup_send_request && power == lfc_pkg::LFC_WAKING;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wakeup not sent");

    property p_wake_clear;
        @(posedge sys_clk) disable iff (rst)
        (wakeup_tx_done && !(ctl_wr && sfr_wdata[`LFC_CTRL_WAKE])) |=> !wakeup_send_request;
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("wakeup request stuck");

    property p_start_master_only;
        @(posedge sys_clk) disable iff (rst)
        (ctl_wr && sfr_wdata[`LFC_CTRL_START] && !frame_done && !frame_error)
            |=> (frame_start_request == $past(master_mode || frame_start_request));
    endproperty
    a_start_master_only: assert property (p_start_master_only) else $error("start gating wrong");

    property p_start_clear;
        @(posedge sys_clk) disable iff (rst)
        ((frame_done || frame_error) && !ctl_wr) |=> !frame_start_request;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start request stuck");

    property p_ctrl_readback;
        @(posedge sys_clk) disable iff (rst)
        (indirect_address_pointer == `LFC_ADDR_CTRL) |=> sfr_rdata[7] == 1'b0 && sfr_rdata[3:2] == 2'b00;
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback) else $error("write-only bit read non-zero");

endmodule : lfc_ctrl

`default_nettype wire

// >>> lfc_defs.svh
// Constants of the frame control register block
//
// Operation
// - Slave: writing one to halt blocks frame processing until next break; reads zero.
// - Slave: with sleep bit one, sleep after sleep-command frame or bus idle timeout.
// - Slave: with sleep bit zero, leave sleep once a wakeup event is received.
// - Direction bit: zero receives response bytes, one transmits them.
// - Controller clears the acknowledge bit itself once the acknowledgement is taken.
// - Writing one to interrupt-clear clears pending-interrupt flag; bit reads zero.
// - Writing one to error-clear clears status and error register error flags; reads zero.
// - Writing one to wakeup request sends a wakeup signal and ends sleep.
// - Controller clears the wakeup request bit itself after handling it.
// - Master: writing one to start request begins a frame transmission.
// - Start request returns to zero on transmission completion or error.
// - Control register sits at indirect location 0x08; all bits reset to zero.
// - Indirect data port reaches the register chosen by the indirect address pointer.
// - Mode bit zero is slave, one is master; marked bits act only in their mode.
// - Pending-interrupt flag reads one while an interrupt is outstanding until cleared.
`ifndef LFC_DEFS_SVH
`define LFC_DEFS_SVH

// ----------------------------------------
// Indirect register locations
// ----------------------------------------
`define LFC_ADDR_CTRL 8'h08
`define LFC_ADDR_STATUS 8'h09
`define LFC_ADDR_ERROR 8'h0a

// ----------------------------------------
// Control register fields and reset
// ----------------------------------------
`define LFC_CTRL_HALT 7
`define LFC_CTRL_SLEEP 6
`define LFC_CTRL_DIR 5
`define LFC_CTRL_ACK 4
`define LFC_CTRL_INTCLR 3
`define LFC_CTRL_ERRCLR 2
`define LFC_CTRL_WAKE 1
`define LFC_CTRL_START 0
`define LFC_CTRL_RESET 8'h00

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define LFC_ST_INT 3
`define LFC_ST_ERR 2
`define LFC_ERR_BITS 5

`endif

// >>> lfc_pkg.sv
// Types of the frame control register block
package lfc_pkg;

    // Power state of the link as seen by the control logic
    typedef enum logic [1:0]
    {
        LFC_AWAKE = 2'b00,
        LFC_ASLEEP = 2'b01,
        LFC_WAKING = 2'b10
    } lfc_power_t;

endpackage : lfc_pkg

// >>> lfc_flag_if.sv
// Carrier between control logic and the flag keeper
`timescale 1ns/1ps
`default_nettype none
`include "lfc_defs.svh"

interface lfc_flag_if;
    logic irq_event;
    logic [`LFC_ERR_BITS-1:0] err_event;
    logic clr_int;
    logic clr_err;
    logic int_pending;
    logic err_any;
    logic [`LFC_ERR_BITS-1:0] err_bits;

    modport ctl
    (
        output irq_event, err_event, clr_int, clr_err,
        input int_pending, err_any, err_bits
    );
    modport flags
    (
        input irq_event, err_event, clr_int, clr_err,
        output int_pending, err_any, err_bits
    );
endinterface : lfc_flag_if

`default_nettype wire

// >>> lfc_flags.sv
// Interrupt and error flag keeper
`timescale 1ns/1ps
`default_nettype none
`include "lfc_defs.svh"

module lfc_flags
(
    input wire logic sys_clk,
    input wire logic rst,
    lfc_flag_if.flags fl
);

    // ----------------------------------------
    // Pending interrupt, a new event beats the clear
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            fl.int_pending <= 1'b0;
        else if (fl.irq_event)
            fl.int_pending <= 1'b1;
        else if (fl.clr_int)
            fl.int_pending <= 1'b0;
    end

    // ----------------------------------------
    // Error register bits, one flop per bit
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `LFC_ERR_BITS; g++)
        begin : g_err
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                    fl.err_bits[g] <= 1'b0;
                else if (fl.err_event[g])
                    fl.err_bits[g] <= 1'b1;
                else if (fl.clr_err)
                    fl.err_bits[g] <= 1'b0;
            end
        end
    endgenerate

    // Summary error flag of the status register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            fl.err_any <= 1'b0;
        else if (|fl.err_event)
            fl.err_any <= 1'b1;
        else if (fl.clr_err)
            fl.err_any <= 1'b0;
    end

    // Clear drops both error views unless an error lands at the same time
    property p_err_clear;
        @(posedge sys_clk) disable iff (rst)
        (fl.clr_err && !(|fl.err_event)) |=> (!fl.err_any && fl.err_bits == '0);
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error flags not cleared");

endmodule : lfc_flags

`default_nettype wire

// >>> lfc_engine_model.sv
// Frame engine stand-in that answers the control block's commands
`timescale 1ns/1ps
`default_nettype none

module lfc_engine_model
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic frame_start,
    input wire logic wakeup_tx,
    input wire logic data_ack,
    input wire logic [3:0] lag,
    input wire logic fail,
    output logic frame_done,
    output logic frame_error,
    output logic wakeup_tx_done,
    output logic ack_taken,
    output logic irq_event
);
    int f_cnt;
    int w_cnt;
    int a_cnt;
    logic ack_seen;

    // Each command arms a countdown of lag cycles, then a one-cycle answer pulse
    always @(posedge sys_clk)
    begin
        #1;
        {frame_done, frame_error, wakeup_tx_done, ack_taken, irq_event} = 5'h00;
        if (rst)
        begin
            f_cnt = 0;
            w_cnt = 0;
            a_cnt = 0;
            ack_seen = 1'b0;
        end
        else
        begin
            frame_done = f_cnt == 1 && !fail;
            frame_error = f_cnt == 1 && fail;
            irq_event = f_cnt == 1;
            wakeup_tx_done = w_cnt == 1;
            ack_taken = a_cnt == 1;
            f_cnt = frame_start ? lag + 1 : (f_cnt > 0 ? f_cnt - 1 : 0);
            w_cnt = wakeup_tx ? lag + 1 : (w_cnt > 0 ? w_cnt - 1 : 0);
            // Only a fresh acknowledge is taken, the level lingers a cycle after
            a_cnt = (data_ack && !ack_seen) ? lag + 1 : (a_cnt > 0 ? a_cnt - 1 : 0);
            ack_seen = data_ack;
        end
    end
endmodule : lfc_engine_model

`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the frame control register block
`timescale 1ns/1ps
`default_nettype none
`include "lfc_defs.svh"

module tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ptr_wr = 1'b0;
    logic data_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic master_mode = 1'b0;
    logic [3:0] evs = 4'h0;
    logic [`LFC_ERR_BITS-1:0] err_event = '0;
    logic [3:0] lag = 4'h0;
    logic fail = 1'b0;
    logic [7:0] sfr_rdata;
    logic frame_start, wakeup_tx, data_ack, transmit_dir, halted, asleep, interrupt_pending, error_pending;
    logic frame_done, frame_error, wakeup_tx_done, ack_taken, irq_event;
    int error_cnt = 0;
    int samples_checked = 0;
    logic started = 1'b0;
    logic wr, m_halt, m_int;
    logic [7:0] m_ptr, m_ctl, exp_rd, exp_out;
    logic [7:0] got_out;
    logic [`LFC_ERR_BITS-1:0] m_err;
    int m_pow;

    always #5 sys_clk = ~sys_clk;

    lfc_ctrl lfc_ctrl_i (.sys_clk(sys_clk), .rst(rst), .ptr_wr(ptr_wr), .data_wr(data_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .master_mode(master_mode), .break_seen(evs[3]),
        .sleep_frame_rx(evs[2]), .idle_timeout(evs[1]), .wakeup_rx(evs[0]), .wakeup_tx_done(wakeup_tx_done),
        .ack_taken(ack_taken), .frame_done(frame_done), .frame_error(frame_error), .irq_event(irq_event),
        .err_event(err_event), .frame_start(frame_start), .wakeup_tx(wakeup_tx), .data_ack(data_ack),
        .transmit_dir(transmit_dir), .halted(halted), .asleep(asleep), .interrupt_pending(interrupt_pending),
        .error_pending(error_pending));

    lfc_engine_model lfc_engine_model_i (.sys_clk(sys_clk), .rst(rst), .frame_start(frame_start),
        .wakeup_tx(wakeup_tx), .data_ack(data_ack), .lag(lag), .fail(fail), .frame_done(frame_done),
        .frame_error(frame_error), .wakeup_tx_done(wakeup_tx_done), .ack_taken(ack_taken),
        .irq_event(irq_event));

    // ----------------------------------------
    // Reference model and comparison
    // ----------------------------------------
    // Steps the expected state; outputs are {start, wake, ack, dir, int, err, halt, asleep}
    always @(posedge sys_clk)
    begin
        started = 1'b1;
        wr = data_wr && m_ptr == `LFC_ADDR_CTRL;
        if (rst)
        begin
            {m_ptr, m_ctl, exp_rd, exp_out, m_halt, m_int, m_err} = '0;
            m_pow = 0;
        end
        else
        begin
            exp_rd = m_ptr == 8'h08 ? m_ctl : m_ptr == 8'h09 ? {4'h0, m_int, |m_err, 2'h0} :
                m_ptr == 8'h0a ? {3'h0, m_err} : 8'h00;
            exp_out[5:2] = {m_ctl[4], m_ctl[5], m_int, |m_err};
            exp_out[7:6] = {wr && master_mode && sfr_wdata[0], wr && sfr_wdata[1]};
            if (exp_out[6])
                m_pow = 2;
            else if (m_pow == 2 && wakeup_tx_done)
                m_pow = 0;
            else if (m_pow == 0 && !master_mode && m_ctl[6] && (evs[2] || evs[1]))
                m_pow = 1;
            else if (m_pow == 1 && !master_mode && !m_ctl[6] && evs[0])
                m_pow = 0;
            m_int = irq_event | (m_int & !(wr && sfr_wdata[3]));
            m_err = err_event | (m_err & ~{`LFC_ERR_BITS{wr && sfr_wdata[2]}});
            m_halt = (wr && !master_mode && sfr_wdata[7]) | (m_halt & !evs[3]);
            m_ctl[0] = exp_out[7] | (m_ctl[0] & !frame_done & !frame_error);
            m_ctl[1] = exp_out[6] | (m_ctl[1] & !wakeup_tx_done);
            m_ctl[4] = (wr && !master_mode && sfr_wdata[4]) | (m_ctl[4] & !ack_taken);
            m_ctl[5] = wr ? sfr_wdata[5] : m_ctl[5];
            m_ctl[6] = (wr && !master_mode) ? sfr_wdata[6] : m_ctl[6];
            m_ptr = ptr_wr ? sfr_wdata : m_ptr;
            exp_out[1:0] = {m_halt, m_pow == 1};
        end
    end

    // Design outputs in the order of the expected output vector
    assign got_out = {frame_start, wakeup_tx, data_ack, transmit_dir,
        interrupt_pending, error_pending, halted, asleep};

    // Compares design and model once settled in every cycle
    always @(negedge sys_clk)
        if (started)
        begin
            chk(sfr_rdata, exp_rd);
            chk(got_out, exp_out);
        end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // ----------------------------------------
    // Stimulus tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic point(input logic [7:0] addr);
        ptr_wr = 1'b1;
        sfr_wdata = addr;
        tick(1);
        ptr_wr = 1'b0;
        tick(2);
    endtask : point

    task automatic put(input logic [7:0] addr, input logic [7:0] data);
        point(addr);
        data_wr = 1'b1;
        sfr_wdata = data;
        tick(1);
        data_wr = 1'b0;
        tick(2);
    endtask : put

    task automatic ev(input int idx);
        evs[idx] = 1'b1;
        tick(1);
        evs = 4'h0;
        tick(2);
    endtask : ev

    // Waits, bounded, until no self-clearing request is outstanding
    task automatic settle();
        int i;
        for (i = 0; i < 40 && (m_ctl[4] || m_ctl[1] || m_ctl[0] || m_pow == 2); i++)
            tick(1);
        tick(3);
    endtask : settle

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    // Hang guard, far beyond the expected run length
    initial
    begin
        #200000;
        error_cnt++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        int i;
        logic [31:0] r;
        r = $urandom(32'h86b3);
        tick(4);
        rst = 1'b0;
        point(8'h08);
        master_mode = 1'b1;
        // Prompt, slow and failing frames after a start request
        for (i = 0; i < 3; i++)
        begin
            lag = 4'(i * 7);
            fail = i == 2;
            put(8'h08, 8'h01);
            settle();
        end
        fail = 1'b0;
        put(8'h08, 8'hf0);
        put(8'h08, 8'h00);
        master_mode = 1'b0;
        put(8'h08, 8'h21);
        lag = 4'h3;
        put(8'h08, 8'h10);
        settle();
        // Flags: a zero write leaves them, the clear bits empty them
        point(8'h09);
        err_event = 5'h15;
        tick(1);
        err_event = 5'h00;
        put(8'h08, 8'h00);
        point(8'h0a);
        put(8'h08, 8'h04);
        put(8'h08, 8'h08);
        point(8'h09);
        // Halt until a break, then sleep and wake paths
        put(8'h08, 8'h80);
        ev(3);
        put(8'h08, 8'h40);
        ev(2);
        ev(0);
        put(8'h08, 8'h00);
        ev(0);
        put(8'h08, 8'h40);
        ev(1);
        put(8'h08, 8'h02);
        settle();
        put(8'h09, 8'hff);
        put(8'h0a, 8'hff);
        point(8'h55);
        // Random traffic over modes, events and locations
        for (i = 0; i < 300; i++)
        begin
            master_mode = 1'($urandom);
            lag = 4'($urandom);
            evs = 4'($urandom);
            err_event = 5'($urandom);
            tick(1);
            evs = 4'h0;
            err_event = 5'h00;
            r = $urandom;
            if (r[8])
                put(8'h08, r[7:0] & 8'hed);
            else
                point({6'h02, r[1:0]});
            settle();
        end
        end_sim();
    end
endmodule : tb_top

`default_nettype wire
